// *** shared/rspwm_params.svh ***
`ifndef RSPWM_PARAMS_SVH
`define RSPWM_PARAMS_SVH
`define RSPWM_CMD_HOLD_CODE 8'h22
`define RSPWM_HOLD_MAX 8'h7F
`define RSPWM_HOLD_FOREVER 8'hFF
`define RSPWM_HOLD_RESET 8'h00
`define RSPWM_HOLD_UNIT_MS 100
`define RSPWM_CLK_HZ 20000000
`define RSPWM_STEP_NS 208000
`define RSPWM_STEP_CYCLES ((`RSPWM_STEP_NS * (`RSPWM_CLK_HZ / 1000000)) / 1000)
`define RSPWM_STEPS 40
`define RSPWM_MAX_HIGH 38
`define RSPWM_UNIT_CYCLES ((`RSPWM_HOLD_UNIT_MS * (`RSPWM_CLK_HZ / 1000)))
`define RSPWM_BASE_STEPS 13
`define RSPWM_DB_10 10
`endif

// *** shared/rspwm_pkg.sv ***
package rspwm_pkg;
    typedef enum logic [3:0] {
        RSPWM_SAMPLE = 4'h1,
        RSPWM_WAIT = 4'h2,
        RSPWM_IDLE = 4'h4,
        RSPWM_SHOW = 4'h8
    } rspwm_state_t;
endpackage

// *** shared/rspwm_tick_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface rspwm_tick_if;
    logic step_tick;
    logic unit_tick;
    modport src (output step_tick, output unit_tick);
    modport dst (input step_tick, input unit_tick);
endinterface
`default_nettype wire

// *** rtl/rspwm_divider.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rspwm_params.svh"
module rspwm_divider #(
    parameter int STEP_CYCLES = `RSPWM_STEP_CYCLES,
    parameter int UNIT_CYCLES = `RSPWM_UNIT_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    rspwm_tick_if.src ticks
);
    typedef struct packed {
        logic [15:0] step_cnt;
        logic [23:0] unit_cnt;
        logic step_tick;
        logic unit_tick;
    } rspwm_div_t;
    rspwm_div_t s_q, s_d;
    always_comb
    begin
        s_d = s_q;
        s_d.step_tick = 1'b0;
        s_d.unit_tick = 1'b0;
        if (s_q.step_cnt == 16'(STEP_CYCLES - 1))
        begin
            s_d.step_cnt = 16'h0000;
            s_d.step_tick = 1'b1;
        end
        else
            s_d.step_cnt = s_q.step_cnt + 16'h0001;
        if (s_q.unit_cnt == 24'(UNIT_CYCLES - 1))
        begin
            s_d.unit_cnt = 24'h000000;
            s_d.unit_tick = 1'b1;
        end
        else
            s_d.unit_cnt = s_q.unit_cnt + 24'h000001;
    end
    always_ff @(posedge clk)
    begin
        if (reset)
            s_q <= '0;
        else
            s_q <= s_d;
    end
    assign ticks.step_tick = s_q.step_tick;
    assign ticks.unit_tick = s_q.unit_tick;
endmodule // rspwm_divider
`default_nettype wire

// *** rtl/rspwm_wave.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rspwm_params.svh"
module rspwm_wave (
    input wire logic clk,
    input wire logic reset,
    rspwm_tick_if.dst ticks,
    input wire logic [5:0] high_steps,
    output logic level
);
    typedef struct packed {
        logic [5:0] pos;
        logic [5:0] latched;
        logic level;
    } rspwm_wave_t;
    rspwm_wave_t s_q, s_d;
    // duty latched at period start so a change never cuts a pulse short
    always_comb
    begin
        s_d = s_q;
        if (ticks.step_tick)
        begin
            if (s_q.pos == 6'(`RSPWM_STEPS - 1))
            begin
                s_d.pos = 6'h00;
                s_d.latched = high_steps;
            end
            else
                s_d.pos = s_q.pos + 6'h01;
        end
        s_d.level = (s_d.pos < s_d.latched);
    end
    always_ff @(posedge clk)
    begin
        if (reset)
            s_q <= '0;
        else
            s_q <= s_d;
    end
    assign level = s_q.level;
    period_len_a: assert property (@(posedge clk) disable iff (reset)
        (ticks.step_tick && s_q.pos == 6'(`RSPWM_STEPS - 1)) |=> s_q.pos == 6'h00)
        else $error("pwm period not 40 steps");
endmodule // rspwm_wave
`default_nettype wire

// *** rtl/rssi_pwm_indicator.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rspwm_params.svh"
// Summary of operation
// - The hold time is 0 to 0x7F units of 100 ms, zero turns the output off and is the default.
// - Duty runs from 0 to 95 percent, with 0 for a signal at or below sensitivity.
// - The period is 40 steps of 0.208 ms and high time is a whole number of steps.
// - Levels 10, 20 and 30 dB above sensitivity give 19, 25 and 31 high steps.
// - After a packet the duty is shown for the hold time, then the output goes low until the next.
// - After the power-up wait the output is low until a packet gives a level.
// - A hold value of 0xFF never times out and always shows the last packet.
// - At power-up the pin is an input and is sampled for the command-mode decision.
// - After the hold-time wait that follows sampling, a non-zero hold time makes the pin an output driven low until a packet.
// - With a hold of 1 to 0x7F the pin stays an input for the hold time after power-up; with 0xFF the wait ends at once.
// - The hold time is read and written by binary code 0x22.
module rssi_pwm_indicator
    import rspwm_pkg::*;
#(
    parameter int STEP_CYCLES = `RSPWM_STEP_CYCLES,
    parameter int UNIT_CYCLES = `RSPWM_UNIT_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic pkt_valid,
    input wire logic [7:0] pkt_db_above,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_wdata,
    output logic cmd_ack,
    output logic [7:0] cmd_rdata,
    input wire logic cfg_pin_in,
    output logic cfg_pin_out,
    output logic cfg_pin_oe,
    output logic command_mode
);
    typedef struct packed {
        rspwm_state_t state;
        logic [7:0] hold;
        logic [7:0] timer;
        logic [5:0] steps;
        logic ack;
        logic [7:0] rdata;
        logic oe;
        logic out;
        logic cmd_mode;
    } rspwm_top_t;
    rspwm_top_t s_q, s_d;
    logic wave_level;
    rspwm_tick_if ticks();

    // 0 at threshold, else 13 steps plus 0.6 step per dB: 10/20/30 dB -> 19/25/31
    function automatic logic [5:0] db_to_steps(input logic [7:0] db);
        logic [11:0] raw;
        raw = 12'h000;
        if (db == 8'h00)
            return 6'h00;
        raw = 12'(`RSPWM_BASE_STEPS) + 12'((12'(db) * 12'h006) / 12'(`RSPWM_DB_10));
        if (raw > 12'(`RSPWM_MAX_HIGH))
            return 6'(`RSPWM_MAX_HIGH);
        return raw[5:0];
    endfunction

    rspwm_divider #(.STEP_CYCLES(STEP_CYCLES), .UNIT_CYCLES(UNIT_CYCLES)) u_div (
        .clk(clk),
        .reset(reset),
        .ticks(ticks)
    );
    rspwm_wave u_wave (
        .clk(clk),
        .reset(reset),
        .ticks(ticks),
        .high_steps(s_q.steps),
        .level(wave_level)
    );

    always_comb
    begin
        s_d = s_q;
        s_d.ack = 1'b0;
        if (cmd_valid && cmd_code == `RSPWM_CMD_HOLD_CODE)
        begin
            s_d.ack = 1'b1;
            s_d.rdata = s_q.hold;
            // values between 0x7F and 0xFF are refused, the stored value stays
            if (cmd_write && (cmd_wdata <= `RSPWM_HOLD_MAX || cmd_wdata == `RSPWM_HOLD_FOREVER))
                s_d.hold = cmd_wdata;
        end
        case (s_q.state)
            RSPWM_SAMPLE:
            begin
                s_d.cmd_mode = cfg_pin_in;
                s_d.timer = s_q.hold;
                s_d.state = RSPWM_WAIT;
            end
            RSPWM_WAIT:
            begin
                // pin stays an input for a hold time of 1 to 0x7F after power-up; with 0xFF the timer is 0 and the wait ends at once
                if (s_q.hold == 8'h00)
                    s_d.timer = 8'h00;
                else if (s_q.timer == 8'h00)
                    s_d.state = RSPWM_IDLE;
                else if (ticks.unit_tick)
                    s_d.timer = s_q.timer - 8'h01;
            end
            RSPWM_IDLE:
            begin
                s_d.steps = 6'h00;
                if (pkt_valid)
                begin
                    s_d.steps = db_to_steps(pkt_db_above);
                    s_d.timer = s_q.hold;
                    s_d.state = RSPWM_SHOW;
                end
            end
            RSPWM_SHOW:
            begin
                if (pkt_valid)
                begin
                    s_d.steps = db_to_steps(pkt_db_above);
                    s_d.timer = s_q.hold;
                end
                else if (s_q.hold != `RSPWM_HOLD_FOREVER && ticks.unit_tick)
                begin
                    if (s_q.timer <= 8'h01)
                    begin
                        s_d.steps = 6'h00;
                        s_d.state = RSPWM_IDLE;
                    end
                    else
                        s_d.timer = s_q.timer - 8'h01;
                end
            end
            default:
                s_d.state = RSPWM_SAMPLE;
        endcase
        // a hold of up to 0x7F written while waiting with a zero stored hold restarts the power-up count from the new value
        if (s_q.state == RSPWM_WAIT && s_q.hold == 8'h00 && cmd_valid && cmd_write
            && cmd_code == `RSPWM_CMD_HOLD_CODE && cmd_wdata <= `RSPWM_HOLD_MAX)
            s_d.timer = cmd_wdata;
        if (s_q.hold == 8'h00 && s_q.state != RSPWM_SAMPLE)
        begin
            s_d.state = RSPWM_WAIT;
            s_d.steps = 6'h00;
        end
        s_d.oe = (s_d.state == RSPWM_IDLE || s_d.state == RSPWM_SHOW);
        s_d.out = s_d.oe && (s_d.state == RSPWM_SHOW) && wave_level;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s_q <= '0;
            s_q.state <= RSPWM_SAMPLE;
            s_q.hold <= `RSPWM_HOLD_RESET;
        end
        else
            s_q <= s_d;
    end

    assign cmd_ack = s_q.ack;
    assign cmd_rdata = s_q.rdata;
    assign cfg_pin_oe = s_q.oe;
    assign cfg_pin_out = s_q.out;
    assign command_mode = s_q.cmd_mode;

    zero_hold_off_a: assert property (@(posedge clk) disable iff (reset)
        (s_q.hold == 8'h00) |=> !cfg_pin_oe)
        else $error("pin driven with zero hold");
    max_duty_a: assert property (@(posedge clk) disable iff (reset)
        s_q.steps <= 6'(`RSPWM_MAX_HIGH))
        else $error("duty above 95 percent");
    chart_point_a: assert property (@(posedge clk) disable iff (reset)
        (pkt_valid && pkt_db_above == 8'h14 && s_q.hold != 8'h00
         && (s_q.state == RSPWM_IDLE || s_q.state == RSPWM_SHOW)) |=> s_q.steps == 6'h19)
        else $error("20 dB not 25 steps");
    idle_low_a: assert property (@(posedge clk) disable iff (reset)
        (s_q.state == RSPWM_IDLE && !pkt_valid) |=> !cfg_pin_out)
        else $error("output high with no packet");

    idle_no_duty_a: assert property (@(posedge clk) disable iff (reset)
        (s_q.state == RSPWM_IDLE) |-> s_q.steps == 6'h00)
        else $error("duty kept while idle");

    wait_no_duty_a: assert property (@(posedge clk) disable iff (reset)
        (s_q.state == RSPWM_WAIT) |=> s_q.steps == 6'h00)
        else $error("duty set during wait");

    wait_not_driven_a: assert property (@(posedge clk) disable iff (reset)
        (s_q.state == RSPWM_WAIT) |-> !cfg_pin_oe)
        else $error("pin driven while waiting");

    show_driven_a: assert property (@(posedge clk) disable iff (reset)
        (s_q.state == RSPWM_SHOW) |-> cfg_pin_oe)
        else $error("pin not driven while showing");

    out_needs_oe_a: assert property (@(posedge clk) disable iff (reset)
        cfg_pin_out |-> cfg_pin_oe)
        else $error("level driven with pin released");

    other_code_a: assert property (@(posedge clk) disable iff (reset)
        (cmd_valid && cmd_code != `RSPWM_CMD_HOLD_CODE) |=> !cmd_ack)
        else $error("foreign code answered");

    hold_write_a: assert property (@(posedge clk) disable iff (reset)
        (cmd_valid && cmd_write && cmd_code == `RSPWM_CMD_HOLD_CODE
         && cmd_wdata <= `RSPWM_HOLD_MAX) |=> s_q.hold == $past(cmd_wdata))
        else $error("hold write not stored");

    hold_refuse_a: assert property (@(posedge clk) disable iff (reset)
        (cmd_valid && cmd_write && cmd_code == `RSPWM_CMD_HOLD_CODE
         && cmd_wdata > `RSPWM_HOLD_MAX && cmd_wdata != `RSPWM_HOLD_FOREVER)
        |=> s_q.hold == $past(s_q.hold))
        else $error("out of range hold stored");

    chart_low_a: assert property (@(posedge clk) disable iff (reset)
        (pkt_valid && pkt_db_above == 8'h0A && s_q.hold != 8'h00 && !cmd_valid
         && (s_q.state == RSPWM_IDLE || s_q.state == RSPWM_SHOW)) |=> s_q.steps == 6'h13)
        else $error("10 dB not 19 steps");

    chart_high_a: assert property (@(posedge clk) disable iff (reset)
        (pkt_valid && pkt_db_above == 8'h1E && s_q.hold != 8'h00 && !cmd_valid
         && (s_q.state == RSPWM_IDLE || s_q.state == RSPWM_SHOW)) |=> s_q.steps == 6'h1F)
        else $error("30 dB not 31 steps");

    floor_level_a: assert property (@(posedge clk) disable iff (reset)
        (pkt_valid && pkt_db_above == 8'h00
         && (s_q.state == RSPWM_IDLE || s_q.state == RSPWM_SHOW)) |=> s_q.steps == 6'h00)
        else $error("floor level gave duty");

    mode_kept_a: assert property (@(posedge clk) disable iff (reset)
        (s_q.state != RSPWM_SAMPLE) |=> $stable(command_mode))
        else $error("mode changed after sampling");
    forever_hold_a: assert property (@(posedge clk) disable iff (reset)
        (s_q.state == RSPWM_SHOW && s_q.hold == `RSPWM_HOLD_FOREVER
         && $stable(s_q.hold)) |=> s_q.state == RSPWM_SHOW)
        else $error("0xFF hold timed out");
    sample_once_a: assert property (@(posedge clk) disable iff (reset)
        (s_q.state == RSPWM_SAMPLE) |=> (s_q.state == RSPWM_WAIT && !cfg_pin_oe))
        else $error("sampling did not lead to wait");
    timeout_low_a: assert property (@(posedge clk) disable iff (reset)
        (s_q.state == RSPWM_SHOW && s_q.hold != `RSPWM_HOLD_FOREVER && s_q.hold != 8'h00
         && !pkt_valid && ticks.unit_tick && s_q.timer <= 8'h01) |=> s_q.steps == 6'h00)
        else $error("hold expiry did not clear duty");
    cmd_answer_a: assert property (@(posedge clk) disable iff (reset)
        (cmd_valid && cmd_code == `RSPWM_CMD_HOLD_CODE) |=> (cmd_ack && cmd_rdata == $past(s_q.hold)))
        else $error("hold command not answered");
    pin_input_wait_a: assert property (@(posedge clk) disable iff (reset)
        (s_q.state == RSPWM_WAIT) |=> (!cfg_pin_oe || s_q.timer == 8'h00))
        else $error("pin driven during wait");
endmodule // rssi_pwm_indicator
`default_nettype wire

// *** tb/rspwm_pin_watch.sv ***
`timescale 1ns/1ps
`default_nettype none
module rspwm_pin_watch #(
    parameter logic HOST_LEVEL = 1'b1
) (
    input wire logic clk,
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic pin_in
);
    // the host holds its strap level only while the device leaves the pin as an input
    assign pin_in = pin_oe ? pin_out : HOST_LEVEL;
    // counts cycles the device itself drives high, so a host level never looks like duty
    task automatic measure(input int n, output int hi);
        hi = 0;
        repeat (n)
        begin
            @(posedge clk);
            #1;
            if (pin_out === 1'b1 && pin_oe === 1'b1)
                hi++;
        end
    endtask
endmodule // rspwm_pin_watch
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int STEP = 4;
    localparam int UNIT = 50;
    localparam int PER = STEP * 40;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic pkt_valid = 1'b0;
    logic [7:0] pkt_db_above = 8'h00;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic [7:0] cmd_code = 8'h00;
    logic [7:0] cmd_wdata = 8'h00;
    logic cmd_ack, cfg_pin_in, cfg_pin_out, cfg_pin_oe, command_mode;
    logic [7:0] cmd_rdata;
    logic [31:0] rng = 32'h00000045;
    int error_cnt = 0;
    int n_compared = 0;
    int hi;
    always #25 clk = ~clk;
    rssi_pwm_indicator #(.STEP_CYCLES(STEP), .UNIT_CYCLES(UNIT)) DUT (.clk(clk), .reset(reset),
        .pkt_valid(pkt_valid), .pkt_db_above(pkt_db_above), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_ack(cmd_ack),
        .cmd_rdata(cmd_rdata), .cfg_pin_in(cfg_pin_in), .cfg_pin_out(cfg_pin_out),
        .cfg_pin_oe(cfg_pin_oe), .command_mode(command_mode));
    rspwm_pin_watch #(.HOST_LEVEL(1'b1)) watch (.clk(clk), .pin_out(cfg_pin_out),
        .pin_oe(cfg_pin_oe), .pin_in(cfg_pin_in));
    task automatic complete_run;
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    function automatic logic [15:0] exp_high(input logic [7:0] db);
        int s;
        s = (db == 8'h00) ? 0 : 13 + (db * 6) / 10;
        if (s > 38)
            s = 38;
        return 16'(s * STEP);
    endfunction
    task automatic cmd(input logic wr, input logic [7:0] code, input logic [7:0] data,
        input logic ack_exp, input logic [7:0] rd_exp);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_code <= code;
        cmd_wdata <= data;
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1;
        chk("cmd_ack", 16'(ack_exp), 16'(cmd_ack));
        if (ack_exp)
            chk("cmd_rdata", 16'(rd_exp), 16'(cmd_rdata));
    endtask
    // the new duty starts at the next period, so skip two periods before measuring one
    task automatic pkt(input logic [7:0] db);
        @(posedge clk);
        pkt_valid <= 1'b1;
        pkt_db_above <= db;
        @(posedge clk);
        pkt_valid <= 1'b0;
        repeat (2 * PER) @(posedge clk);
        watch.measure(PER, hi);
        chk("high time", exp_high(db), 16'(hi));
    endtask
    task automatic wait_oe(input int lim);
        int k;
        k = 0;
        while (cfg_pin_oe !== 1'b1 && k < lim)
        begin
            @(posedge clk);
            k++;
        end
        #1;
        chk("cfg_pin_oe", 16'h0001, 16'(cfg_pin_oe));
    endtask
    initial
    begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        complete_run();
    end
    initial
    begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        chk("cfg_pin_oe", 16'h0000, 16'(cfg_pin_oe));
        chk("command_mode", 16'h0001, 16'(command_mode));
        cmd(1'b0, 8'h22, 8'h00, 1'b1, 8'h00);
        cmd(1'b1, 8'h21, 8'h05, 1'b0, 8'h00);
        cmd(1'b1, 8'h22, 8'h80, 1'b1, 8'h00);
        cmd(1'b1, 8'h22, 8'h7F, 1'b1, 8'h00);
        cmd(1'b0, 8'h22, 8'h00, 1'b1, 8'h7F);
        repeat (UNIT * 8'h7F / 2) @(posedge clk);
        chk("cfg_pin_oe", 16'h0000, 16'(cfg_pin_oe));
        wait_oe(UNIT * 8'h7F);
        chk("cfg_pin_out", 16'h0000, 16'(cfg_pin_out));
        watch.measure(PER, hi);
        chk("idle high time", 16'h0000, 16'(hi));
        pkt(8'h00);
        pkt(8'h0A);
        pkt(8'h14);
        pkt(8'h1E);
        pkt(8'hFF);
        repeat (4)
        begin
            rng = xs(rng);
            pkt(8'(rng % 41));
        end
        repeat (UNIT * 8'h80) @(posedge clk);
        watch.measure(PER, hi);
        chk("expired high time", 16'h0000, 16'(hi));
        cmd(1'b1, 8'h22, 8'hFF, 1'b1, 8'h7F);
        wait_oe(UNIT * 256);
        pkt(8'h14);
        repeat (UNIT * 8'h90) @(posedge clk);
        watch.measure(PER, hi);
        chk("held high time", exp_high(8'h14), 16'(hi));
        complete_run();
    end
endmodule // tb
`default_nettype wire
